// File: rxoh_pkg.sv
`default_nettype none

package rxoh_pkg;

  // Number of overhead channels
  localparam int unsigned CHANNELS = 3;

  // Core clock rate and the overhead clock period it divides down to
  localparam longint unsigned CORE_CLK_HZ    = 64'd10_000_000;
  localparam longint unsigned OHCLK_PERIOD_NS = 64'd800;
  localparam longint unsigned NS_PER_S        = 64'd1_000_000_000;

  // Core cycles per overhead clock period (rounded down, at least two)
  localparam int unsigned OHCLK_DIV =
    (OHCLK_PERIOD_NS * CORE_CLK_HZ / NS_PER_S) < 64'd2 ? 2 :
    int'(OHCLK_PERIOD_NS * CORE_CLK_HZ / NS_PER_S);

  // Bits in one overhead byte; the STS-1 frame pulse spans the first byte
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned FCNT_W    = 3;
  localparam logic [FCNT_W-1:0] FCNT_FIRST_BYTE = 3'h7;
  localparam logic [FCNT_W-1:0] FCNT_ZERO       = 3'h0;

  // Mode encoding of the per-channel mode input and register
  typedef enum logic [0:0] {
    RXOH_MODE_DS3E3 = 1'b0,
    RXOH_MODE_STS1  = 1'b1
  } rxoh_mode_t;

  // Reset values
  localparam logic RST_BIT = 1'b0;

endpackage

`default_nettype wire

// File: rxoh_clkgen.sv
`default_nettype none

// Free-running overhead clock divider for one channel
module rxoh_clkgen #(
  parameter int unsigned DIV = rxoh_pkg::OHCLK_DIV
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  output var  logic clk_out,
  output var  logic load
);
  import rxoh_pkg::*;

  localparam int unsigned CNT_W = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CNT_W-1:0] LAST      = CNT_W'(DIV - 1);
  localparam logic [CNT_W-1:0] HALF      = CNT_W'(DIV / 2);
  localparam logic [CNT_W-1:0] PRE_FALL  = CNT_W'(DIV / 2 - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

  // Refuse divisions that cannot give a clean two-phase clock
  if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
    $error("rxoh_clkgen: DIV must be even and at least 2");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             clk;
    logic             load;
  } rxoh_div_t;

  rxoh_div_t st;
  rxoh_div_t next_st;

  // Clock is high for the first half of the count, low for the second;
  // load marks the core cycle whose closing edge is the falling edge
  always_comb begin
    next_st      = st;
    next_st.cnt  = (st.cnt == LAST) ? CNT_ZERO : st.cnt + 1'b1;
    next_st.clk  = (next_st.cnt < HALF);
    next_st.load = (next_st.cnt == PRE_FALL);
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{cnt: CNT_ZERO, clk: 1'b1, load: (PRE_FALL == CNT_ZERO)};
    end else begin
      st <= next_st;
    end
  end

  assign clk_out = st.clk;
  assign load    = st.load;

endmodule

`default_nettype wire

// File: rxoh_port.sv
`default_nettype none

module rxoh_port #(
  parameter int unsigned DIV = rxoh_pkg::OHCLK_DIV
) (
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  input  wire logic [rxoh_pkg::CHANNELS-1:0]  sts1_mode,
  input  wire logic [rxoh_pkg::CHANNELS-1:0]  ovh_valid,
  input  wire logic [rxoh_pkg::CHANNELS-1:0]  ovh_bit,
  input  wire logic [rxoh_pkg::CHANNELS-1:0]  ovh_path,
  input  wire logic [rxoh_pkg::CHANNELS-1:0]  ovh_frame_start,
  output var  logic [rxoh_pkg::CHANNELS-1:0]  ovh_ready,
  output var  logic [rxoh_pkg::CHANNELS-1:0]  ovh_underrun,
  output var  logic [rxoh_pkg::CHANNELS-1:0]  rx_overhead_clock_out,
  output var  logic [rxoh_pkg::CHANNELS-1:0]  rx_overhead_data_out,
  output var  logic [rxoh_pkg::CHANNELS-1:0]  rx_overhead_qualifier_out,
  output var  logic [rxoh_pkg::CHANNELS-1:0]  rx_overhead_frame_pulse
);
  import rxoh_pkg::*;

  typedef struct packed {
    logic [CHANNELS-1:0]             data;
    logic [CHANNELS-1:0]             qual;
    logic [CHANNELS-1:0]             frame;
    logic [CHANNELS-1:0]             mode;
    logic [CHANNELS-1:0]             underrun;
    logic [CHANNELS-1:0][FCNT_W-1:0] fcnt;
  } rxoh_state_t;

  rxoh_state_t         st;
  rxoh_state_t         next_st;
  logic [CHANNELS-1:0] load;

  // Per-channel decode of the current offer, settled before the load edge
  logic [CHANNELS-1:0]             starve;
  logic [CHANNELS-1:0]             eff_mode;
  logic [CHANNELS-1:0]             is_sts1;
  logic [CHANNELS-1:0]             byte_busy;
  logic [CHANNELS-1:0][FCNT_W-1:0] fcnt_step;

  // Refuse channel counts and dividers the formatter cannot serve
  if (CHANNELS < 1) begin : g_bad_channels
    $error("rxoh_port: at least one channel is needed");
  end
  if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
    $error("rxoh_port: DIV must be even and at least 2");
  end
  if (FCNT_FIRST_BYTE != FCNT_W'(BYTE_BITS - 1)) begin : g_bad_fcnt
    $error("rxoh_port: first-byte count does not match the byte width");
  end

  // One free-running divider per channel, index n drives port n
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    rxoh_clkgen #(
      .DIV (DIV)
    ) u_clkgen (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk_out  (rx_overhead_clock_out[ch]),
      .load     (load[ch])
    );
  end

  // Source handshake: a bit is taken when valid meets the load cycle
  assign ovh_ready = load;

  // Offer decode for each channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_dec
    // A load cycle with nothing offered is an underrun
    assign starve[ch]    = load[ch] & ~ovh_valid[ch];
    // Mode may only switch at a frame boundary or while idle, so one
    // frame never mixes the two formats
    assign eff_mode[ch]  = (!ovh_valid[ch] || ovh_frame_start[ch]) ? sts1_mode[ch] : st.mode[ch];
    assign is_sts1[ch]   = (eff_mode[ch] == RXOH_MODE_STS1);
    // The first-byte window stays open while the count is non-zero
    assign byte_busy[ch] = (st.fcnt[ch] != FCNT_ZERO);
    // Count down one bit per load, resting at zero
    assign fcnt_step[ch] = byte_busy[ch] ? st.fcnt[ch] - 1'b1 : FCNT_ZERO;
  end

  // Output formatting; every field but underrun moves only in a load cycle, whose
  // closing edge is also the falling edge of that channel's clock; underrun clears one core cycle later
  always_comb begin
    next_st          = st;
    next_st.underrun = '0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (load[ch]) begin
        next_st.mode[ch] = eff_mode[ch];
        next_st.fcnt[ch] = fcnt_step[ch];
        if (starve[ch]) begin
          // Starved: hold data; DS3/E3 drops qualifier and frame,
          // STS-1 keeps the qualifier and runs out the first byte
          next_st.underrun[ch] = 1'b1;
          next_st.frame[ch]    = is_sts1[ch] && byte_busy[ch];
          if (!is_sts1[ch]) begin
            next_st.qual[ch] = 1'b0;
          end
        end else if (!is_sts1[ch]) begin
          next_st.data[ch]  = ovh_bit[ch];
          next_st.qual[ch]  = 1'b1;
          next_st.frame[ch] = ovh_frame_start[ch];
          next_st.fcnt[ch]  = FCNT_ZERO;
        end else begin
          next_st.data[ch] = ovh_bit[ch];
          next_st.qual[ch] = ovh_path[ch];
          if (ovh_frame_start[ch]) begin
            next_st.frame[ch] = 1'b1;
            next_st.fcnt[ch]  = FCNT_FIRST_BYTE;
          end else begin
            next_st.frame[ch] = byte_busy[ch];
          end
        end
      end
    end
  end

  // State register; reset leaves every port quiet and DS3/E3 selected
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st.data     <= {CHANNELS{RST_BIT}};
      st.qual     <= {CHANNELS{RST_BIT}};
      st.frame    <= {CHANNELS{RST_BIT}};
      st.mode     <= {CHANNELS{RXOH_MODE_DS3E3}};
      st.underrun <= {CHANNELS{RST_BIT}};
      st.fcnt     <= {CHANNELS{FCNT_ZERO}};
    end else begin
      st <= next_st;
    end
  end

  assign rx_overhead_data_out      = st.data;
  assign rx_overhead_qualifier_out = st.qual;
  assign rx_overhead_frame_pulse   = st.frame;
  assign ovh_underrun              = st.underrun;

endmodule

`default_nettype wire

// File: rxoh_asserts.sv
`default_nettype none
module rxoh_asserts (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [2:0] sts1_mode,
  input wire logic [2:0] ovh_valid,
  input wire logic [2:0] ovh_bit,
  input wire logic [2:0] ovh_path,
  input wire logic [2:0] ovh_frame_start,
  input wire logic [2:0] ovh_ready,
  input wire logic [2:0] ovh_underrun,
  input wire logic [2:0] rx_overhead_clock_out,
  input wire logic [2:0] rx_overhead_data_out,
  input wire logic [2:0] rx_overhead_qualifier_out,
  input wire logic [2:0] rx_overhead_frame_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Channel 0 port and a taken bit, plus a channel 1 STS-1 taken bit
  wire logic k = rx_overhead_clock_out[0];
  wire logic d = rx_overhead_data_out[0];
  wire logic q = rx_overhead_qualifier_out[0];
  wire logic f = rx_overhead_frame_pulse[0];
  wire logic t = ovh_ready[0] && ovh_valid[0];
  wire logic s = ovh_ready[1] && ovh_valid[1] && sts1_mode[1];
  a_data_falls: assert property ($changed(d) |-> $fell(k)) else $error("data moved off fall");
  a_qual_falls: assert property ($changed(q) |-> $fell(k)) else $error("qual moved off fall");
  a_frame_falls: assert property ($changed(f) |-> $fell(k)) else $error("frame moved off fall");
  a_clock_free: assert property ($rose(k) |-> k[*4] ##1 !k[*4] ##1 k) else $error("clock gated");
  a_bit_taken: assert property (t |=> d == $past(ovh_bit[0]) && $fell(k)) else $error("bit lost");
  a_ds3_qual: assert property (ovh_ready[0] && !sts1_mode[0] |=> q == $past(ovh_valid[0])) else $error("qual");
  a_first_bit: assert property (t && !sts1_mode[0] |=> f == $past(ovh_frame_start[0])) else $error("frame");
  a_sts1_path: assert property (s |=> rx_overhead_qualifier_out[1] == $past(ovh_path[1])) else $error("path");
  a_sts1_frame: assert property (s && ovh_frame_start[1] |=> rx_overhead_frame_pulse[1]) else $error("a1");
  a_sts1_qual_edge: assert property ($changed(rx_overhead_qualifier_out[1]) |-> $fell(rx_overhead_clock_out[1]))
    else $error("sts1 qual moved off fall");
  a_starve_flag: assert property (ovh_ready[2] && !ovh_valid[2] |=> ovh_underrun[2])
    else $error("underrun not flagged");
endmodule
bind rxoh_port rxoh_asserts u_rxoh_asserts (.*);
`default_nettype wire

// File: rxoh_sink.sv
`default_nettype none
module rxoh_sink (
  input  wire logic [2:0]      ohclk,
  input  wire logic [2:0]      d,
  input  wire logic [2:0]      q,
  input  wire logic [2:0]      f,
  output wire logic [2:0][2:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  // Capture data, qualifier and frame on each channel clock rise
  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic [2:0] cap;
    always @(posedge ohclk[i]) begin
      cap <= {d[i], q[i], f[i]};
    end
    assign got[i] = cap;
  end
endmodule
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic            core_clk;
  logic            rstn = 1'b0;
  logic [2:0]      sts1_mode = 3'h6;
  logic [2:0]      ovh_valid = 3'h0;
  logic [2:0]      ovh_bit = 3'h0;
  logic [2:0]      ovh_path = 3'h0;
  logic [2:0]      ovh_frame_start = 3'h0;
  logic [2:0]      ovh_ready, ohclk, d, q, f, under;
  logic [2:0][2:0] got;
  int              bad_count = 0;
  int              cmp_count = 0;
  rxoh_port u_rxoh_port (.core_clk, .rstn, .sts1_mode, .ovh_valid, .ovh_bit, .ovh_path, .ovh_frame_start,
    .ovh_ready, .ovh_underrun(under), .rx_overhead_clock_out(ohclk), .rx_overhead_data_out(d),
    .rx_overhead_qualifier_out(q), .rx_overhead_frame_pulse(f));
  rxoh_sink u_rxoh_sink (.ohclk, .d, .q, .f, .got);
  // Core clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [2:0] s, input logic [2:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Offer one bit, wait until taken, judge what the far end captured
  task automatic send(input int c, input logic b, input logic p, input logic s, input logic [2:0] e);
    int n;
    n = 0;
    ovh_valid[c] = 1'b1;
    ovh_bit[c] = b;
    ovh_path[c] = p;
    ovh_frame_start[c] = s;
    while (ovh_ready[c] !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    repeat (5) @(negedge core_clk);
    chk("port sample", got[c], e);
  endtask
  // DS3/E3 bits on channel 0, back to back
  task automatic t_ds3();
    send(0, 1'b1, 1'b0, 1'b1, 3'h7);
    send(0, 1'b0, 1'b0, 1'b0, 3'h2);
    send(0, 1'b1, 1'b0, 1'b0, 3'h6);
    ovh_valid[0] = 1'b0;
  endtask
  // STS-1 transport then path bits on channel 1, frame restarted
  task automatic t_sts1();
    send(1, 1'b1, 1'b0, 1'b1, 3'h5);
    send(1, 1'b0, 1'b0, 1'b0, 3'h1);
    send(1, 1'b1, 1'b1, 1'b0, 3'h7);
    send(1, 1'b0, 1'b1, 1'b1, 3'h3);
    ovh_valid[1] = 1'b0;
  endtask
  // Idle channels: DS3/E3 qualifier drops, data held, no crosstalk
  task automatic t_idle();
    repeat (16) @(negedge core_clk);
    chk("ds3 idle", got[0], 3'h4);
    chk("ch2 quiet", got[2], 3'h0);
    while (ovh_ready[2] !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    chk("ch2 underrun", {2'h0, under[2]}, 3'h1);
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    t_ds3();
    t_sts1();
    t_idle();
    give_verdict();
  end
  // Watchdog
  initial begin
    #200us;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
